// file: include/tmr_link_if.sv
// open-drain two-wire link plus alert line between host and device
// assumes pull-ups: a line is low only while some end enables a low drive
`timescale 1ns/10ps
`default_nettype none
interface tmr_link_if;
  logic scl_o, scl_oe_n;
  logic sda_h_o, sda_h_oe_n;
  logic sda_d_o, sda_d_oe_n;
  logic alert_o, alert_oe_n;
  logic scl, sda, message_alert_n;

  assign scl             = scl_oe_n | scl_o;
  assign sda             = (sda_h_oe_n | sda_h_o) & (sda_d_oe_n | sda_d_o);
  assign message_alert_n = alert_oe_n | alert_o;

  modport device (input scl, sda, output sda_d_o, sda_d_oe_n, alert_o, alert_oe_n);
  modport host (input sda, message_alert_n, output scl_o, scl_oe_n, sda_h_o, sda_h_oe_n);
endinterface : tmr_link_if
`default_nettype wire

// file: include/tmr_pkg.sv
// constants and types shared by both ends of the touch report link
// assumes a 10 MHz system clock on both ends
package tmr_pkg;

  // ---------------------------------------------------------------
  // device addressing and message layout
  // ---------------------------------------------------------------
  localparam logic [6:0]  TMR_I2C_ADDR   = 7'h4B;
  localparam logic [15:0] TMR_COUNT_ADDR = 16'h012E;
  localparam logic [15:0] TMR_MSG_ADDR   = 16'h012F;
  localparam logic [7:0]  TMR_ID_FIRST   = 8'h03;
  localparam logic [7:0]  TMR_ID_INVALID = 8'hFF;
  localparam int          TMR_SLOTS      = 16;
  localparam logic [2:0]  TMR_B_ID       = 3'h0;
  localparam logic [2:0]  TMR_B_FLAGS    = 3'h1;
  localparam logic [2:0]  TMR_B_XHI      = 3'h2;
  localparam logic [2:0]  TMR_B_YHI      = 3'h3;
  localparam logic [2:0]  TMR_B_XYLO     = 3'h4;
  localparam logic [2:0]  TMR_B_AREA     = 3'h5;
  localparam logic [2:0]  TMR_B_LAST     = 3'h7;
  localparam logic [2:0]  TMR_BIT_LAST   = 3'h7;
  localparam logic [3:0]  TMR_BIT_ACK    = 4'h8;

  // ---------------------------------------------------------------
  // host timing: one quarter of a link clock period
  // ---------------------------------------------------------------
  localparam int          TMR_CLK_NS     = 100;
  localparam int          TMR_QTR_NS     = 2500;
  localparam int          TMR_QTR_CYC    = TMR_QTR_NS / TMR_CLK_NS;
  localparam logic [7:0]  TMR_QTR_MAX    = 8'(TMR_QTR_CYC - 1);

  // ---------------------------------------------------------------
  // host register map (byte addresses) and fields
  // ---------------------------------------------------------------
  localparam logic [4:0]  TMR_REG_CTRL   = 5'h00;
  localparam logic [4:0]  TMR_REG_STAT   = 5'h04;
  localparam logic [4:0]  TMR_REG_IRQ    = 5'h08;
  localparam logic [4:0]  TMR_REG_MASK   = 5'h0C;
  localparam logic [4:0]  TMR_REG_MSGL   = 5'h10;
  localparam logic [4:0]  TMR_REG_MSGH   = 5'h14;
  localparam int          TMR_CTRL_GO    = 0;
  localparam int          TMR_CTRL_CONT  = 1;
  localparam int          TMR_CTRL_AUTO  = 2;
  localparam int          TMR_IRQ_MSG    = 0;
  localparam int          TMR_IRQ_DONE   = 1;
  localparam int          TMR_IRQ_NAK    = 2;

  typedef enum logic [2:0] {
    TMR_D_IDLE, TMR_D_RX, TMR_D_RXACK, TMR_D_TX, TMR_D_TXACK
  } tmr_dst_t;

  typedef enum logic [1:0] {
    TMR_H_IDLE, TMR_H_START, TMR_H_BIT, TMR_H_STOP
  } tmr_hst_t;

  typedef enum logic [2:0] {
    TMR_S_AW, TMR_S_PL, TMR_S_PH, TMR_S_AR, TMR_S_CNT, TMR_S_MSG
  } tmr_seq_t;

endpackage : tmr_pkg

// file: test/tb_top.sv
// bench: host and device joined by one link, host driven over Avalon-MM
// assumes both ends share clk_sys_i and nrst_i
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import tmr_pkg::*;
  logic        clk_sys_i, nrst_i, avs_read, avs_write, evt_valid, evt_ready, pend, wait_r, irq;
  logic [4:0]  avs_address;
  logic [3:0]  evt_slot, evt_flags;
  logic [11:0] evt_x, evt_y;
  logic [7:0]  evt_area;
  logic [31:0] avs_wd, avs_rd, q;
  int          miscompares, n_checks;
  tmr_link_if link ();
  tmr_device tmr_device_inst (.clk_sys_i, .nrst_i, .link(link), .evt_valid_i(evt_valid),
    .evt_slot_i(evt_slot), .evt_flags_i(evt_flags), .evt_x_i(evt_x), .evt_y_i(evt_y),
    .evt_area_i(evt_area), .evt_ready_o(evt_ready), .msg_pending_o(pend));
  tmr_host tmr_host_inst (.clk_sys_i, .nrst_i, .link(link), .avs_address_i(avs_address),
    .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_wd),
    .avs_readdata_o(avs_rd), .avs_waitrequest_o(wait_r), .irq_o(irq));
  tmr_link_asserts tmr_link_asserts_inst (.clk_sys_i, .nrst_i, .scl(link.scl), .sda(link.sda),
    .message_alert_n(link.message_alert_n), .alert_o(link.alert_o), .sda_d_o(link.sda_d_o),
    .sda_d_oe_n(link.sda_d_oe_n), .msg_pending_o(pend));
  initial begin
    clk_sys_i = 0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // ----
  // tasks
  // ----
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    {avs_read, avs_write, avs_address, avs_wd} <= {!w, w, a, d};
    do @(posedge clk_sys_i); while (wait_r !== 1'b0);
    q = avs_rd;
    {avs_read, avs_write} <= 2'h0;
  endtask : bus
  task automatic ev(input logic [3:0] s, input logic [11:0] x, input logic [7:0] ar);
    @(posedge clk_sys_i);
    {evt_valid, evt_slot, evt_flags, evt_x, evt_y, evt_area} <= {1'b1, s, 4'hA, x, 12'h123, ar};
    @(posedge clk_sys_i);
    evt_valid <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
  endtask : ev
  task automatic run(input logic [31:0] c);
    int i;
    bus(1, TMR_REG_IRQ, 32'h7);
    bus(1, TMR_REG_CTRL, c);
    i = 0;
    do begin bus(0, TMR_REG_IRQ, 32'h0); i++; end while (q[TMR_IRQ_DONE] !== 1'b1 && i < 10000);
    chk("done", 32'h1, 32'(q[TMR_IRQ_DONE]));
    repeat (20) @(posedge clk_sys_i);
  endtask : run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // ----
  // scenarios
  // ----
  task automatic test_idle();
    chk("alert", 32'h1, 32'(link.message_alert_n));
    chk("ready", 32'h1, 32'(evt_ready));
    run(32'h1);
    bus(0, TMR_REG_MSGL, 32'h0);
    chk("empty id", 32'hFF, 32'(q[7:0]));
    bus(0, 5'h18, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test idle done");
  endtask : test_idle
  task automatic test_one();
    ev(4'h2, 12'hABC, 8'h5A);
    chk("alert", 32'h0, 32'(link.message_alert_n));
    run(32'h1);
    bus(0, TMR_REG_MSGL, 32'h0);
    chk("msg low", 32'h12ABA005, q);
    bus(0, TMR_REG_MSGH, 32'h0);
    chk("msg high", 32'h00005AC3, q);
    bus(0, TMR_REG_STAT, 32'h0);
    chk("count", 32'h1, 32'(q[15:8]));
    chk("alert", 32'h1, 32'(link.message_alert_n));
    $display("test one done");
  endtask : test_one
  task automatic test_two();
    ev(4'hF, 12'h001, 8'h01);
    ev(4'h0, 12'h002, 8'h02);
    run(32'h1);
    bus(0, TMR_REG_MSGL, 32'h0);
    chk("first id", 32'h03, 32'(q[7:0]));
    chk("alert", 32'h0, 32'(link.message_alert_n));
    run(32'h1);
    bus(0, TMR_REG_MSGL, 32'h0);
    chk("last id", 32'h12, 32'(q[7:0]));
    $display("test two done");
  endtask : test_two
  task automatic test_cont();
    ev(4'h5, 12'h003, 8'h03);
    ev(4'h6, 12'h004, 8'h04);
    run(32'h3);
    bus(0, TMR_REG_STAT, 32'h0);
    chk("count", 32'h2, 32'(q[15:8]));
    chk("alert", 32'h1, 32'(link.message_alert_n));
    bus(0, TMR_REG_MSGL, 32'h0);
    chk("cont low", 32'h1200A0FF, q);
    $display("test continuous done");
  endtask : test_cont
  task automatic test_auto();
    ev(4'h1, 12'h005, 8'h05);
    run(32'h4);
    bus(0, TMR_REG_MSGL, 32'h0);
    chk("auto id", 32'h04, 32'(q[7:0]));
    bus(1, TMR_REG_CTRL, 32'h0);
    $display("test auto done");
  endtask : test_auto
  task automatic test_irq();
    bus(1, TMR_REG_MASK, 32'h2);
    repeat (3) @(posedge clk_sys_i);
    chk("irq", 32'h1, 32'(irq));
    bus(1, TMR_REG_MASK, 32'h0);
    repeat (3) @(posedge clk_sys_i);
    chk("irq masked", 32'h0, 32'(irq));
    bus(1, TMR_REG_MASK, 32'h2);
    bus(1, TMR_REG_IRQ, 32'h2);
    repeat (3) @(posedge clk_sys_i);
    chk("irq cleared", 32'h0, 32'(irq));
    $display("test irq done");
  endtask : test_irq
  // ----
  // main sequence
  // ----
  initial begin
    {avs_read, avs_write, avs_address, avs_wd, evt_valid, evt_slot} = '0;
    {evt_flags, evt_x, evt_y, evt_area, nrst_i} = '0;
    repeat (20) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    test_idle();
    test_one();
    test_two();
    test_cont();
    test_auto();
    test_irq();
    give_verdict();
  end
  initial begin
    #9500000;
    miscompares++;
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire

// file: test/tmr_link_asserts.sv
// concurrent checks on the resolved link wires and the device's drives
// assumes one instance beside the link interface in tb_top
`timescale 1ns/10ps
`default_nettype none
module tmr_link_asserts (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic message_alert_n,
  input wire logic alert_o,
  input wire logic sda_d_o,
  input wire logic sda_d_oe_n,
  input wire logic msg_pending_o
);
  // ----
  // transfer tracking
  // ----
  logic busy_q;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) busy_q <= 1'b0;
    else if (scl && $past(scl) && $fell(sda)) busy_q <= 1'b1;
    else if (scl && $past(scl) && $rose(sda)) busy_q <= 1'b0;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  a_open_drain: assert property (!alert_o && !sda_d_o &&
    (message_alert_n || msg_pending_o))
    else $error("device drives a line high or alert low with nothing pending");
  a_pend_alert: assert property ($rose(msg_pending_o) && !busy_q |-> ##[0:2] !message_alert_n)
    else $error("alert not low for new message");
  a_idle_low: assert property ((!busy_q && msg_pending_o) [*8] |-> !message_alert_n)
    else $error("alert high while message pending");
  a_rise_busy: assert property ($rose(message_alert_n) |-> busy_q)
    else $error("alert released outside a transfer");
  a_rise_scl_low: assert property ($rose(message_alert_n) |-> !scl)
    else $error("alert released before next byte loaded");
  a_fall_idle: assert property ($fell(message_alert_n) |-> !busy_q)
    else $error("alert fell inside a transfer");
  a_none_high: assert property ((!busy_q && !msg_pending_o) [*3] |-> message_alert_n)
    else $error("alert low with nothing pending");
  a_sda_hold: assert property (scl && $past(scl) |-> $stable(sda_d_oe_n))
    else $error("device changed data while clock high");
  c_release: cover property ($rose(message_alert_n));
  c_stop: cover property ($fell(busy_q));
  c_refall: cover property ($fell(message_alert_n));
endmodule : tmr_link_asserts
`default_nettype wire

// file: verilog/tmr_device.sv
// touch controller end: two-wire target, message slots, alert line
// assumes the link clock is slow against clk_sys_i (many cycles per phase)
`timescale 1ns/10ps
`default_nettype none
module tmr_device
  import tmr_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  tmr_link_if.device       link,
  input  wire logic        evt_valid_i,
  input  wire logic [3:0]  evt_slot_i,
  input  wire logic [3:0]  evt_flags_i,
  input  wire logic [11:0] evt_x_i,
  input  wire logic [11:0] evt_y_i,
  input  wire logic [7:0]  evt_area_i,
  output logic             evt_ready_o,
  output logic             msg_pending_o
);

  // ---------------------------------------------------------------
  // link sampling and bus conditions
  // ---------------------------------------------------------------
  logic scl_s, sda_s, scl_p, sda_p;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  tmr_sync #(.W(2)) u_sync (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .d_i       ({link.scl, link.sda}),
    .q_o       ({scl_s, sda_s})
  );

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_p <= scl_s;
      sda_p <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_p;
  assign scl_fall  = ~scl_s & scl_p;
  assign bus_start = scl_s & scl_p & sda_p & ~sda_s;
  assign bus_stop  = scl_s & scl_p & ~sda_p & sda_s;

  // ---------------------------------------------------------------
  // message slots, one per contact
  // ---------------------------------------------------------------
  logic [35:0]          rec_q [TMR_SLOTS];
  logic [TMR_SLOTS-1:0] pending_q;
  logic                 clr_en;
  logic [3:0]           cur_idx_q;
  logic                 cur_vld_q;
  logic [35:0]          cur_rec_q;
  logic [3:0]           low_idx;
  logic [4:0]           pend_cnt;

  genvar g;
  generate
    for (g = 0; g < TMR_SLOTS; g++) begin : g_slot
      always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
          rec_q[g]     <= '0;
          pending_q[g] <= 1'b0;
        end else if (evt_valid_i && evt_slot_i == 4'(g)) begin
          // a new report wins over the clear of the same slot
          rec_q[g]     <= {evt_flags_i, evt_x_i, evt_y_i, evt_area_i};
          pending_q[g] <= 1'b1;
        end else if (clr_en && cur_idx_q == 4'(g)) begin
          pending_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_comb begin
    low_idx  = '0;
    pend_cnt = '0;
    for (int i = TMR_SLOTS - 1; i >= 0; i--) begin
      if (pending_q[i]) begin
        low_idx = 4'(i);
      end
      pend_cnt = pend_cnt + 5'(pending_q[i]);
    end
  end

  // ---------------------------------------------------------------
  // byte served at the address pointer
  // ---------------------------------------------------------------
  tmr_dst_t    st_q;
  logic [15:0] ptr_q, base_q, ptr_home;
  logic [2:0]  bidx_q, bit_q;
  logic [7:0]  sh_q, nxt_byte;
  logic [35:0] m;
  logic [1:0]  wcnt_q;
  logic        done_q, addr_ph_q, rd_q, hold_q, load, msg_first;

  assign m         = cur_vld_q ? cur_rec_q : '0;
  assign msg_first = (ptr_q == TMR_MSG_ADDR) && (bidx_q == TMR_B_ID);
  assign ptr_home  = (ptr_q == TMR_MSG_ADDR) ? TMR_COUNT_ADDR : base_q;
  assign load      = scl_fall && ((st_q == TMR_D_RXACK && rd_q) || st_q == TMR_D_TXACK);
  assign clr_en    = load && (ptr_q == TMR_MSG_ADDR) && (bidx_q == TMR_B_FLAGS) && cur_vld_q;

  always_comb begin
    nxt_byte = '0;
    if (ptr_q == TMR_COUNT_ADDR) begin
      nxt_byte = {3'h0, pend_cnt};
    end else if (ptr_q == TMR_MSG_ADDR) begin
      case (bidx_q)
        TMR_B_ID:    nxt_byte = (|pending_q) ? TMR_ID_FIRST + {4'h0, low_idx}
                                             : TMR_ID_INVALID;
        TMR_B_FLAGS: nxt_byte = {m[35:32], 4'h0};
        TMR_B_XHI:   nxt_byte = m[31:24];
        TMR_B_YHI:   nxt_byte = m[19:12];
        TMR_B_XYLO:  nxt_byte = {m[23:20], m[11:8]};
        TMR_B_AREA:  nxt_byte = m[7:0];
        default:     nxt_byte = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // two-wire target state machine
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q              <= TMR_D_IDLE;
      bit_q             <= '0;
      sh_q              <= '0;
      done_q            <= 1'b0;
      addr_ph_q         <= 1'b0;
      rd_q              <= 1'b0;
      wcnt_q            <= '0;
      ptr_q             <= TMR_COUNT_ADDR;
      base_q            <= TMR_COUNT_ADDR;
      bidx_q            <= '0;
      hold_q            <= 1'b0;
      cur_idx_q         <= '0;
      cur_vld_q         <= 1'b0;
      cur_rec_q         <= '0;
      link.sda_d_oe_n   <= 1'b1;
    end else if (bus_stop) begin
      st_q            <= TMR_D_IDLE;
      hold_q          <= 1'b0;
      ptr_q           <= ptr_home;
      bidx_q          <= '0;
      link.sda_d_oe_n <= 1'b1;
    end else if (bus_start) begin
      st_q            <= TMR_D_RX;
      bit_q           <= '0;
      done_q          <= 1'b0;
      addr_ph_q       <= 1'b1;
      link.sda_d_oe_n <= 1'b1;
    end else begin
      if (load) begin
        sh_q            <= nxt_byte;
        link.sda_d_oe_n <= nxt_byte[7];
        bit_q           <= '0;
        st_q            <= TMR_D_TX;
        if (msg_first) begin
          cur_idx_q <= low_idx;
          cur_vld_q <= |pending_q;
          cur_rec_q <= rec_q[low_idx];
        end
        if (clr_en) begin
          hold_q <= 1'b1;
        end
      end
      case (st_q)
        TMR_D_RX: begin
          if (scl_rise) begin
            sh_q  <= {sh_q[6:0], sda_s};
            bit_q <= bit_q + 3'h1;
            if (bit_q == TMR_BIT_LAST) begin
              done_q <= 1'b1;
            end
          end else if (scl_fall && done_q) begin
            done_q <= 1'b0;
            if (addr_ph_q) begin
              addr_ph_q <= 1'b0;
              wcnt_q    <= '0;
              if (sh_q[7:1] == TMR_I2C_ADDR) begin
                rd_q            <= sh_q[0];
                link.sda_d_oe_n <= 1'b0;
                st_q            <= TMR_D_RXACK;
              end else begin
                st_q <= TMR_D_IDLE;
              end
            end else begin
              if (wcnt_q == 2'h0) begin
                ptr_q[7:0]  <= sh_q;
                base_q[7:0] <= sh_q;
              end else if (wcnt_q == 2'h1) begin
                ptr_q[15:8]  <= sh_q;
                base_q[15:8] <= sh_q;
                bidx_q       <= '0;
              end
              if (wcnt_q != 2'h2) begin
                wcnt_q <= wcnt_q + 2'h1;
              end
              link.sda_d_oe_n <= 1'b0;
              st_q            <= TMR_D_RXACK;
            end
          end
        end
        TMR_D_RXACK: begin
          if (scl_fall && !rd_q) begin
            link.sda_d_oe_n <= 1'b1;
            bit_q           <= '0;
            st_q            <= TMR_D_RX;
          end
        end
        TMR_D_TX: begin
          if (scl_fall) begin
            if (bit_q == TMR_BIT_LAST) begin
              link.sda_d_oe_n <= 1'b1;
              st_q            <= TMR_D_TXACK;
            end else begin
              link.sda_d_oe_n <= sh_q[6];
              sh_q            <= {sh_q[6:0], 1'b0};
              bit_q           <= bit_q + 3'h1;
            end
          end
        end
        TMR_D_TXACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              st_q   <= TMR_D_IDLE;
              ptr_q  <= ptr_home;
              bidx_q <= '0;
            end else if (ptr_q == TMR_MSG_ADDR) begin
              bidx_q <= bidx_q + 3'h1; // wraps to the next message
            end else begin
              ptr_q <= ptr_q + 16'h0001;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // alert line and user-side status
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link.alert_oe_n <= 1'b1;
      msg_pending_o   <= 1'b0;
      evt_ready_o     <= 1'b0;
    end else begin
      // level is held high from the load of a message's flags byte until the stop
      link.alert_oe_n <= ~(|pending_q & ~hold_q);
      msg_pending_o   <= |pending_q;
      evt_ready_o     <= 1'b1;
    end
  end

  assign link.sda_d_o = 1'b0;
  assign link.alert_o = 1'b0;

endmodule : tmr_device
`default_nettype wire

// file: verilog/tmr_host.sv
// host end: two-wire controller reading touch messages, Avalon-MM slave
// assumes software polls or takes irq_o; the link runs with no clock stretching
`timescale 1ns/10ps
`default_nettype none
module tmr_host
  import tmr_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  tmr_link_if.host         link,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             irq_o
);

  // ---------------------------------------------------------------
  // sampling, quarter-bit tick, registers
  // ---------------------------------------------------------------
  logic       sda_s, alert_s, tick, acc, go_q, cont_q, auto_q, alert_seen_q;
  logic [7:0] qcnt_q, cnt_q, out_q, in_q;
  logic [2:0] irq_set, irq_q, mask_q, mb_q;
  logic [7:0] msg_q [8];
  tmr_hst_t   st_q;
  tmr_seq_t   seq_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic       nak_q, rd_ph, send_nak;

  tmr_sync #(.W(2)) u_sync (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .d_i       ({link.sda, link.message_alert_n}),
    .q_o       ({sda_s, alert_s})
  );

  assign tick = (qcnt_q == TMR_QTR_MAX);
  assign acc  = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      qcnt_q <= '0;
    end else begin
      qcnt_q <= tick ? 8'h00 : qcnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= '0;
      cont_q            <= 1'b0;
      auto_q            <= 1'b0;
      mask_q            <= '0;
      irq_q             <= '0;
      irq_o             <= 1'b0;
    end else begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
      if (avs_read_i && avs_waitrequest_o) begin
        case (avs_address_i)
          TMR_REG_CTRL: avs_readdata_o <= {29'h0, auto_q, cont_q, go_q};
          TMR_REG_STAT: avs_readdata_o <= {16'h0, cnt_q, 6'h0, alert_seen_q,
                                           st_q != TMR_H_IDLE};
          TMR_REG_IRQ:  avs_readdata_o <= {29'h0, irq_q};
          TMR_REG_MASK: avs_readdata_o <= {29'h0, mask_q};
          TMR_REG_MSGL: avs_readdata_o <= {msg_q[3], msg_q[2], msg_q[1], msg_q[0]};
          TMR_REG_MSGH: avs_readdata_o <= {msg_q[7], msg_q[6], msg_q[5], msg_q[4]};
          default:      avs_readdata_o <= '0;
        endcase
      end
      if (acc && avs_write_i && avs_address_i == TMR_REG_CTRL) begin
        cont_q <= avs_writedata_i[TMR_CTRL_CONT];
        auto_q <= avs_writedata_i[TMR_CTRL_AUTO];
      end
      if (acc && avs_write_i && avs_address_i == TMR_REG_MASK) begin
        mask_q <= avs_writedata_i[2:0];
      end
      // set wins over a write-one clear in the same cycle
      if (acc && avs_write_i && avs_address_i == TMR_REG_IRQ) begin
        irq_q <= (irq_q & ~avs_writedata_i[2:0]) | irq_set;
      end else begin
        irq_q <= irq_q | irq_set;
      end
      irq_o <= |(irq_q & mask_q);
    end
  end

  // ---------------------------------------------------------------
  // controller: address write, restart, count, messages
  // ---------------------------------------------------------------
  assign rd_ph    = (seq_q == TMR_S_CNT) || (seq_q == TMR_S_MSG);
  assign send_nak = (seq_q == TMR_S_MSG) &&
                    ((cont_q && mb_q == TMR_B_ID && in_q == TMR_ID_INVALID) ||
                     (!cont_q && mb_q == TMR_B_LAST));

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q            <= TMR_H_IDLE;
      seq_q           <= TMR_S_AW;
      ph_q            <= '0;
      bit_q           <= '0;
      out_q           <= '0;
      in_q            <= '0;
      nak_q           <= 1'b0;
      mb_q            <= '0;
      cnt_q           <= '0;
      go_q            <= 1'b0;
      alert_seen_q    <= 1'b0;
      irq_set         <= '0;
      msg_q           <= '{default: 8'h00};
      link.scl_oe_n   <= 1'b1;
      link.sda_h_oe_n <= 1'b1;
    end else begin
      irq_set <= '0;
      if (acc && avs_write_i && avs_address_i == TMR_REG_CTRL) begin
        go_q <= avs_writedata_i[TMR_CTRL_GO];
      end
      case (st_q)
        TMR_H_IDLE: begin
          alert_seen_q <= ~alert_s;
          // alert is read as a level, never an edge
          if (tick && (go_q || (auto_q && !alert_s))) begin
            go_q  <= 1'b0;
            seq_q <= TMR_S_AW;
            ph_q  <= '0;
            st_q  <= TMR_H_START;
          end
        end
        TMR_H_START: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h0) begin
              link.sda_h_oe_n <= 1'b1;
              link.scl_oe_n   <= 1'b1;
            end else if (ph_q == 2'h1) begin
              link.sda_h_oe_n <= 1'b0;
            end else begin
              link.scl_oe_n <= 1'b0;
              out_q <= {TMR_I2C_ADDR, seq_q == TMR_S_AR};
              bit_q <= '0;
              ph_q  <= '0;
              st_q  <= TMR_H_BIT;
            end
          end
        end
        TMR_H_BIT: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: link.sda_h_oe_n <= (bit_q == TMR_BIT_ACK) ? (rd_ph ? send_nak : 1'b1)
                                                              : out_q[7];
              2'h1: link.scl_oe_n <= 1'b1;
              2'h2: begin
                if (bit_q == TMR_BIT_ACK) begin
                  nak_q <= sda_s;
                end else begin
                  in_q <= {in_q[6:0], sda_s};
                end
              end
              default: begin
                link.scl_oe_n <= 1'b0;
                out_q         <= {out_q[6:0], 1'b1};
                bit_q         <= bit_q + 4'h1;
                if (bit_q == TMR_BIT_ACK) begin
                  bit_q <= '0;
                  out_q <= 8'hFF;
                  case (seq_q)
                    TMR_S_AW:  out_q <= TMR_COUNT_ADDR[7:0];
                    TMR_S_PL:  out_q <= TMR_COUNT_ADDR[15:8];
                    default:   out_q <= 8'hFF;
                  endcase
                  if (!rd_ph && nak_q) begin
                    irq_set[TMR_IRQ_NAK] <= 1'b1;
                    st_q                 <= TMR_H_STOP;
                  end else if (seq_q == TMR_S_PH) begin
                    seq_q <= TMR_S_AR;
                    st_q  <= TMR_H_START;
                  end else if (seq_q == TMR_S_CNT) begin
                    cnt_q <= in_q;
                    mb_q  <= '0;
                    seq_q <= TMR_S_MSG;
                  end else if (seq_q == TMR_S_MSG) begin
                    msg_q[mb_q] <= in_q;
                    mb_q        <= mb_q + 3'h1;
                    if (mb_q == TMR_B_LAST) begin
                      irq_set[TMR_IRQ_MSG] <= 1'b1;
                      alert_seen_q         <= ~alert_s;
                    end
                    if (send_nak) begin
                      st_q <= TMR_H_STOP;
                    end
                  end else begin
                    seq_q <= tmr_seq_t'(seq_q + 3'h1);
                  end
                end
              end
            endcase
          end
        end
        TMR_H_STOP: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: link.sda_h_oe_n <= 1'b0;
              2'h1: link.scl_oe_n <= 1'b1;
              2'h2: link.sda_h_oe_n <= 1'b1;
              default: begin
                irq_set[TMR_IRQ_DONE] <= 1'b1;
                st_q                  <= TMR_H_IDLE;
              end
            endcase
          end
        end
        default: st_q <= TMR_H_IDLE;
      endcase
    end
  end

  // the alert line is only ever read here, never driven
  assign link.scl_o   = 1'b0;
  assign link.sda_h_o = 1'b0;

endmodule : tmr_host
`default_nettype wire

// file: verilog/tmr_sync.sv
// two flip-flop synchroniser for a vector of independent levels
// assumes each bit is a slow level from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module tmr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= '1;
      q_o    <= '1;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : tmr_sync
`default_nettype wire
